// ===== verification/mrt_pulse_src.sv
`timescale 1ns/1ns
module mrt_pulse_src (
  input wire logic clock, // bench clock
  input wire logic go, // start a burst
  input wire logic [7:0] pulses, // pulses in one burst
  input wire logic [7:0] half_len, // cycles high, then as many low
  output logic level, // level put on the pin
  output logic drive_en // high while this source drives the pin
);
  // released pin follows the timer when it drives, else falls to the load's pull-down, resolved by the bench
  initial begin
    level = 1'b0;
    drive_en = 1'b0;
    forever begin
      @(posedge clock);
      if (go) begin
        drive_en <= 1'b1;
        for (int p = 0; p < pulses; p++) begin
          // edges stay many count-source cycles apart
          level <= 1'b1;
          repeat (half_len) @(posedge clock);
          level <= 1'b0;
          repeat (half_len) @(posedge clock);
        end
        drive_en <= 1'b0;
      end
    end
  end
endmodule

// ===== verification/multimode_reload_timer_test.sv
`timescale 1ns/1ns
`include "mrt_map.svh"
module multimode_reload_timer_test;
  import mrt_pkg::*;
  localparam int TIMEOUT = 20000;
  localparam int DIV[3] = '{1, 8, 32};
  localparam mrt_mode_e DST[3] = '{MRT_ONESHOT, MRT_PWM16, MRT_PWM8};
  logic clock, sys_rst, wr_en, rd_en, go, src_lvl, src_en, rd_seen;
  logic pin_out, pin_oe, pin_wire, irq_request;
  logic [7:0] n_pulses, half_len;
  mrt_addr_t addr;
  mrt_word_t wr_data, rd_data;
  mrt_word_t exp_q[$];
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;

  mrt_timer DUT (
    .clock(clock), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .timer_io_pin_in(pin_wire),
    .timer_io_pin_out(pin_out), .timer_io_pin_oe(pin_oe), .irq_request(irq_request)
  );
  mrt_pulse_src src (
    .clock(clock), .go(go), .pulses(n_pulses), .half_len(half_len),
    .level(src_lvl), .drive_en(src_en)
  );
  // external trigger wins, otherwise the timer, otherwise the pull-down
  assign pin_wire = src_en ? src_lvl : (pin_oe ? pin_out : 1'b0);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk(input mrt_word_t got, input mrt_word_t exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr(input mrt_addr_t a, input mrt_word_t d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input mrt_addr_t a, input mrt_word_t e);
    exp_q.push_back(e);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(posedge clock);
  endtask

  // which 0 watches the request bit, 1 the pin output
  task automatic wait_sig(input bit which, input logic v, input int lim);
    int n;
    n = 0;
    while (((which ? pin_out : irq_request) !== v) && n < lim) begin
      @(posedge clock);
      n++;
    end
    chk({15'h0000, which ? pin_out : irq_request}, {15'h0000, v});
  endtask

  task automatic pulse(input int n, input int h);
    n_pulses <= 8'(n);
    half_len <= 8'(h);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
  endtask

  task automatic done(input string name);
    $display("test %s done at %0t", name, $time);
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clock) rd_seen <= rd_en;
  always @(negedge clock) begin
    if (rd_seen) begin
      chk(rd_data, exp_q.pop_front());
    end
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == TIMEOUT) begin
      error_cnt++;
      $display("timeout after %0d cycles", cyc);
      give_verdict();
    end
  end

  initial begin
    mrt_word_t v;
    int t1;
    int rl;
    sys_rst = 1'b1;
    addr = 8'h00;
    wr_data = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    go = 1'b0;
    n_pulses = 8'h00;
    half_len = 8'h01;
    void'($urandom(98151));
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rd(`MRT_ADDR_START, 16'h0000);
    rd(`MRT_ADDR_MODE, 16'h0080);
    rd(`MRT_ADDR_IRQ, 16'h0000);
    rd(8'h14, 16'h0000);
    done("reset");
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      wr(`MRT_ADDR_TIMER, v);
      rd(`MRT_ADDR_TIMER, v);
    end
    done("stopped load");
    // bit7 written 1 so the flag from reset survives
    wr(`MRT_ADDR_TIMER, 16'hffff);
    wr(`MRT_ADDR_MODE, 16'h0083);
    wr(`MRT_ADDR_IRQ, 16'h0000);
    wr(`MRT_ADDR_START, 16'h0001);
    pulse(2, 30);
    repeat (12) @(posedge clock);
    chk({15'h0000, irq_request}, 16'h0000);
    wait_sig(0, 1'b1, 70);
    rd(`MRT_ADDR_TIMER, 16'hffc4);
    wr(`MRT_ADDR_MODE, 16'h0003);
    rd(`MRT_ADDR_MODE, 16'h0083);
    repeat (80) @(posedge clock);
    wr(`MRT_ADDR_IRQ, 16'h0000);
    wr(`MRT_ADDR_MODE, 16'h000b);
    wait_sig(0, 1'b1, 4);
    wr(`MRT_ADDR_IRQ, 16'h0000);
    pulse(1, 20);
    wait_sig(0, 1'b1, 30);
    wr(`MRT_ADDR_IRQ, 16'h0000);
    wait_sig(0, 1'b1, 30);
    rd(`MRT_ADDR_TIMER, 16'hffec);
    wr(`MRT_ADDR_START, 16'h0000);
    wr(`MRT_ADDR_MODE, 16'h000b);
    rd(`MRT_ADDR_MODE, 16'h000b);
    done("measure");
    for (int s = 0; s < 2; s++) begin
      for (int d = 0; d < 3; d++) begin
        wr(`MRT_ADDR_MODE, 16'(s ? MRT_EVENT : MRT_TIMER));
        wr(`MRT_ADDR_IRQ, 16'h0000);
        rd(`MRT_ADDR_IRQ, 16'h0000);
        wr(`MRT_ADDR_MODE, 16'(DST[d]));
        rd(`MRT_ADDR_IRQ, 16'h0001);
      end
    end
    done("mode entry");
    wr(`MRT_ADDR_MODE, 16'(MRT_TIMER));
    for (int c = 0; c < 3; c++) begin
      rl = 7 + $urandom % 8;
      wr(`MRT_ADDR_START, 16'h0000);
      wr(`MRT_ADDR_CLKSEL, 16'(c));
      wr(`MRT_ADDR_TIMER, 16'(rl));
      wr(`MRT_ADDR_IRQ, 16'h0000);
      wr(`MRT_ADDR_START, 16'h0001);
      wait_sig(0, 1'b1, 4 * (rl + 1) * DIV[c]);
      t1 = cyc;
      wr(`MRT_ADDR_IRQ, 16'h0000);
      wait_sig(0, 1'b0, 4);
      wait_sig(0, 1'b1, 4 * (rl + 1) * DIV[c]);
      chk(16'(cyc - t1), 16'((rl + 1) * DIV[c]));
    end
    done("reload period");
    wr(`MRT_ADDR_START, 16'h0000);
    wr(`MRT_ADDR_CLKSEL, 16'h0000);
    wr(`MRT_ADDR_TIMER, 16'h0100);
    wr(`MRT_ADDR_MODE, 16'(MRT_ONESHOT));
    wr(`MRT_ADDR_IRQ, 16'h0000);
    wr(`MRT_ADDR_START, 16'h0001);
    pulse(1, 4);
    wait_sig(1, 1'b1, 20);
    wr(`MRT_ADDR_START, 16'h0000);
    wait_sig(1, 1'b0, 4);
    wait_sig(0, 1'b1, 4);
    rd(`MRT_ADDR_TIMER, 16'h0100);
    wr(`MRT_ADDR_TIMER, 16'h0014);
    wr(`MRT_ADDR_START, 16'h0001);
    pulse(1, 4);
    wait_sig(1, 1'b1, 20);
    repeat (10) @(posedge clock);
    pulse(1, 4);
    repeat (16) @(posedge clock);
    chk({15'h0000, pin_out}, 16'h0001);
    wait_sig(1, 1'b0, 40);
    done("one-shot");
    wr(`MRT_ADDR_START, 16'h0000);
    wr(`MRT_ADDR_TIMER, 16'h0080);
    wr(`MRT_ADDR_MODE, 16'(MRT_PWM8));
    for (int k = 0; k < 2; k++) begin
      wr(`MRT_ADDR_START, 16'h0001);
      wait_sig(1, 1'b1, 600);
      if (k) begin
        wait_sig(1, 1'b0, 200);
      end
      wr(`MRT_ADDR_IRQ, 16'h0000);
      wr(`MRT_ADDR_START, 16'h0000);
      repeat (4) @(posedge clock);
      chk({15'h0000, pin_out}, 16'h0000);
      chk({15'h0000, irq_request}, k ? 16'h0000 : 16'h0001);
    end
    done("pwm stop");
    give_verdict();
  end
endmodule

// ===== verilog/mrt_map.svh
`ifndef MRT_MAP_SVH
`define MRT_MAP_SVH

// register byte addresses
`define MRT_ADDR_START 8'h00
`define MRT_ADDR_MODE 8'h04
`define MRT_ADDR_TIMER 8'h08
`define MRT_ADDR_IRQ 8'h0c
`define MRT_ADDR_CLKSEL 8'h10

// field positions
`define MRT_START_BIT 0
`define MRT_MODE_LSB 0
`define MRT_MODE_MSB 2
`define MRT_SEL_BIT 3
`define MRT_EDGE_BIT 4
`define MRT_OVF_BIT 7
`define MRT_IRQ_BIT 0
`define MRT_CLKSEL_LSB 0
`define MRT_CLKSEL_MSB 1

// reset values
`define MRT_START_RST 1'b0
`define MRT_OVF_RST 1'b1
`define MRT_IRQ_RST 1'b0
`define MRT_WORD_RST 16'h0000
`define MRT_CLKSEL_RST 2'h0

// counter constants
`define MRT_CNT_MAX 16'hffff
`define MRT_CNT_ZERO 16'h0000
`define MRT_BYTE_ZERO 8'h00

// count source divider restart value, step and terminal counts
`define MRT_DIV_ZERO 5'h00
`define MRT_DIV_ONE 5'h01
`define MRT_DIV1_MAX 5'h00
`define MRT_DIV8_MAX 5'h07
`define MRT_DIV32_MAX 5'h1f

// clock select codes
`define MRT_CLKSEL_DIV1 2'h0
`define MRT_CLKSEL_DIV8 2'h1
`define MRT_CLKSEL_DIV32 2'h2

// one-shot retrigger stages
`define MRT_STAGE_IDLE 2'h0
`define MRT_STAGE_DOWN 2'h1
`define MRT_STAGE_LOAD 2'h2

`endif

// ===== verilog/mrt_pkg.sv
package mrt_pkg;
  typedef enum logic [2:0] {
    MRT_TIMER,
    MRT_EVENT,
    MRT_ONESHOT,
    MRT_MEASURE,
    MRT_PWM16,
    MRT_PWM8
  } mrt_mode_e;
  typedef logic [15:0] mrt_word_t;
  typedef logic [7:0] mrt_addr_t;
endpackage

// ===== verilog/mrt_sync.sv
`timescale 1ns/1ns
module mrt_sync (
  input wire logic clock, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic async_in, // level from outside the clock domain
  output logic sync_out // synchronised level
);
  logic stage1;
  logic next_stage1;
  logic next_sync_out;

  always_comb begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule

// ===== verilog/mrt_timer.sv
`timescale 1ns/1ns
`include "mrt_map.svh"
module mrt_timer (
  input wire logic clock, // 10 mhz system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire mrt_pkg::mrt_addr_t addr, // register byte address
  input wire mrt_pkg::mrt_word_t wr_data, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  output mrt_pkg::mrt_word_t rd_data, // read data, cycle after strobe
  input wire logic timer_io_pin_in, // pin level in
  output logic timer_io_pin_out, // pin level out
  output logic timer_io_pin_oe, // pin drive enable
  output logic irq_request // interrupt request bit
);
  import mrt_pkg::*;

  logic start, next_start;
  mrt_mode_e mode, next_mode, wr_mode;
  logic meas_sel, next_meas_sel;
  logic edge_pol, next_edge_pol;
  logic ovf, next_ovf;
  logic [1:0] clk_sel, next_clk_sel;
  mrt_word_t reload, next_reload;
  mrt_word_t cnt, next_cnt;
  logic next_irq;
  logic os_active, next_os_active;
  logic [1:0] os_stage, next_os_stage;
  logic first_edge, next_first_edge;
  logic next_pin_out, next_pin_oe;
  mrt_word_t next_rd_data;
  logic [4:0] div_cnt, next_div_cnt, div_max;
  logic pin_s, pin_d, next_pin_d;
  logic rise, fall, eff_edge, src_tick, tick, at_zero, reload_instant;
  logic is_pwm, wr_is_pwm, wr_start, wr_stop;
  mrt_word_t elapsed;

  mrt_sync u_pin_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .async_in(timer_io_pin_in),
    .sync_out(pin_s)
  );

  always_comb begin
    case (clk_sel)
      `MRT_CLKSEL_DIV1: div_max = `MRT_DIV1_MAX;
      `MRT_CLKSEL_DIV8: div_max = `MRT_DIV8_MAX;
      `MRT_CLKSEL_DIV32: div_max = `MRT_DIV32_MAX;
      default: div_max = `MRT_DIV32_MAX;
    endcase
    case (wr_data[`MRT_MODE_MSB:`MRT_MODE_LSB])
      3'h1: wr_mode = MRT_EVENT;
      3'h2: wr_mode = MRT_ONESHOT;
      3'h3: wr_mode = MRT_MEASURE;
      3'h4: wr_mode = MRT_PWM16;
      3'h5: wr_mode = MRT_PWM8;
      default: wr_mode = MRT_TIMER;
    endcase
    src_tick = (div_cnt == div_max);
    rise = pin_s & ~pin_d;
    fall = ~pin_s & pin_d;
    // width measurement takes both edges
    if (mode == MRT_MEASURE && meas_sel) begin
      eff_edge = rise | fall;
    end else begin
      eff_edge = edge_pol ? fall : rise;
    end
    tick = (mode == MRT_EVENT) ? eff_edge : src_tick;
    is_pwm = (mode == MRT_PWM16) || (mode == MRT_PWM8);
    wr_is_pwm = (wr_mode == MRT_PWM16) || (wr_mode == MRT_PWM8);
    if (mode == MRT_PWM8) begin
      at_zero = (cnt[7:0] == `MRT_BYTE_ZERO);
    end else begin
      at_zero = (cnt == `MRT_CNT_ZERO);
    end
    reload_instant = start && tick && at_zero && (mode == MRT_TIMER || mode == MRT_EVENT);
    wr_start = wr_en && (addr == `MRT_ADDR_START) && wr_data[`MRT_START_BIT];
    wr_stop = wr_en && (addr == `MRT_ADDR_START) && !wr_data[`MRT_START_BIT];
  end

  always_comb begin
    next_start = start;
    next_mode = mode;
    next_meas_sel = meas_sel;
    next_edge_pol = edge_pol;
    next_ovf = ovf;
    next_clk_sel = clk_sel;
    next_reload = reload;
    next_cnt = cnt;
    next_irq = irq_request;
    next_os_active = os_active;
    next_os_stage = os_stage;
    next_first_edge = first_edge;
    next_pin_out = timer_io_pin_out;
    next_rd_data = `MRT_WORD_RST;
    next_pin_d = pin_s;
    next_div_cnt = src_tick ? `MRT_DIV_ZERO : div_cnt + `MRT_DIV_ONE;
    elapsed = `MRT_WORD_RST;

    // software clears first so a same-cycle hardware set wins
    if (wr_en && addr == `MRT_ADDR_IRQ && !wr_data[`MRT_IRQ_BIT]) begin
      next_irq = 1'b0;
    end
    if (wr_en && addr == `MRT_ADDR_MODE && !wr_data[`MRT_OVF_BIT] && !start) begin
      next_ovf = 1'b0;
    end

    case (mode)
      MRT_TIMER, MRT_EVENT: begin
        if (start && tick) begin
          if (at_zero) begin
            next_cnt = reload;
            next_irq = 1'b1;
          end else begin
            next_cnt = cnt - 16'h0001;
          end
        end
      end
      MRT_ONESHOT: begin
        if (start && os_active && src_tick) begin
          if (os_stage == `MRT_STAGE_DOWN) begin
            next_cnt = cnt - 16'h0001;
            next_os_stage = `MRT_STAGE_LOAD;
          end else if (os_stage == `MRT_STAGE_LOAD) begin
            next_cnt = reload;
            next_os_stage = `MRT_STAGE_IDLE;
          end else if (at_zero) begin
            next_cnt = reload;
            next_os_active = 1'b0;
            next_pin_out = 1'b0;
            next_irq = 1'b1;
          end else begin
            next_cnt = cnt - 16'h0001;
          end
        end
        if (start && eff_edge) begin
          if (!os_active) begin
            next_os_active = 1'b1;
            next_pin_out = 1'b1;
          end else begin
            // partner keeps retriggers over one source cycle apart
            next_os_stage = `MRT_STAGE_DOWN;
          end
        end
      end
      MRT_MEASURE: begin
        if (start && src_tick) begin
          next_cnt = cnt - 16'h0001;
          if (at_zero) begin
            next_ovf = 1'b1;
            next_irq = 1'b1;
          end
        end
        if (start && eff_edge) begin
          next_reload = cnt;
          next_cnt = `MRT_CNT_MAX;
          if (first_edge) begin
            next_first_edge = 1'b0;
          end else begin
            next_irq = 1'b1;
          end
        end
      end
      MRT_PWM16, MRT_PWM8: begin
        if (start && src_tick) begin
          if (at_zero) begin
            next_cnt = `MRT_CNT_MAX;
            next_irq = 1'b1;
          end else begin
            next_cnt = cnt - 16'h0001;
          end
        end
        // duty takes effect on the next cycle, a zero duty gives a flat low output
        elapsed = ~next_cnt;
        if (mode == MRT_PWM8) begin
          next_pin_out = start && (elapsed[7:0] < reload[7:0]);
        end else begin
          next_pin_out = start && (elapsed < reload);
        end
      end
      default: begin
        next_cnt = cnt;
      end
    endcase

    if (wr_stop && start) begin
      if (mode == MRT_ONESHOT && os_active) begin
        next_cnt = reload;
        next_os_active = 1'b0;
        next_os_stage = `MRT_STAGE_IDLE;
        next_pin_out = 1'b0;
        next_irq = 1'b1;
      end
      if (is_pwm) begin
        next_pin_out = 1'b0;
        if (timer_io_pin_out) begin
          next_irq = 1'b1;
        end
      end
    end
    if (wr_en && addr == `MRT_ADDR_START) begin
      next_start = wr_data[`MRT_START_BIT];
      if (wr_start && !start) begin
        next_first_edge = 1'b1;
        if (is_pwm) begin
          next_cnt = `MRT_CNT_MAX;
        end
      end
    end
    if (wr_en && addr == `MRT_ADDR_MODE) begin
      next_mode = wr_mode;
      next_meas_sel = wr_data[`MRT_SEL_BIT];
      next_edge_pol = wr_data[`MRT_EDGE_BIT];
      if (wr_mode != mode && wr_mode == MRT_ONESHOT) begin
        next_irq = 1'b1;
      end
      if (wr_mode != mode && wr_is_pwm && !is_pwm) begin
        next_irq = 1'b1;
      end
      if (start && mode == MRT_MEASURE && wr_mode == MRT_MEASURE &&
          wr_data[`MRT_SEL_BIT] != meas_sel) begin
        next_irq = 1'b1;
      end
      if (wr_mode != mode) begin
        next_os_active = 1'b0;
        next_os_stage = `MRT_STAGE_IDLE;
        next_pin_out = 1'b0;
      end
    end
    if (wr_en && addr == `MRT_ADDR_TIMER) begin
      next_reload = wr_data;
      if (!start) begin
        next_cnt = wr_data;
      end
    end
    if (wr_en && addr == `MRT_ADDR_CLKSEL) begin
      next_clk_sel = wr_data[`MRT_CLKSEL_MSB:`MRT_CLKSEL_LSB];
    end
    next_pin_oe = (next_mode == MRT_ONESHOT) || (next_mode == MRT_PWM16) ||
                  (next_mode == MRT_PWM8);

    if (rd_en) begin
      case (addr)
        `MRT_ADDR_START: next_rd_data = {15'h0000, start};
        `MRT_ADDR_MODE: next_rd_data = {8'h00, ovf, 2'h0, edge_pol, meas_sel, mode};
        `MRT_ADDR_TIMER: begin
          if (mode == MRT_MEASURE) begin
            next_rd_data = reload;
          end else if (reload_instant) begin
            next_rd_data = `MRT_CNT_MAX;
          end else begin
            next_rd_data = cnt;
          end
        end
        `MRT_ADDR_IRQ: next_rd_data = {15'h0000, irq_request};
        `MRT_ADDR_CLKSEL: next_rd_data = {14'h0000, clk_sel};
        default: next_rd_data = `MRT_WORD_RST;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      start <= `MRT_START_RST;
      mode <= MRT_TIMER;
      meas_sel <= 1'b0;
      edge_pol <= 1'b0;
      ovf <= `MRT_OVF_RST;
      clk_sel <= `MRT_CLKSEL_RST;
      reload <= `MRT_WORD_RST;
      cnt <= `MRT_WORD_RST;
      irq_request <= `MRT_IRQ_RST;
      os_active <= 1'b0;
      os_stage <= `MRT_STAGE_IDLE;
      first_edge <= 1'b1;
      timer_io_pin_out <= 1'b0;
      timer_io_pin_oe <= 1'b0;
      rd_data <= `MRT_WORD_RST;
      div_cnt <= `MRT_DIV_ZERO;
      pin_d <= 1'b0;
    end else begin
      start <= next_start;
      mode <= next_mode;
      meas_sel <= next_meas_sel;
      edge_pol <= next_edge_pol;
      ovf <= next_ovf;
      clk_sel <= next_clk_sel;
      reload <= next_reload;
      cnt <= next_cnt;
      irq_request <= next_irq;
      os_active <= next_os_active;
      os_stage <= next_os_stage;
      first_edge <= next_first_edge;
      timer_io_pin_out <= next_pin_out;
      timer_io_pin_oe <= next_pin_oe;
      rd_data <= next_rd_data;
      div_cnt <= next_div_cnt;
      pin_d <= next_pin_d;
    end
  end

  a_start_reset: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(sys_rst) |-> !start)
    else $error("start flag not clear after reset");
  a_reload_read: assert property (@(posedge clock) disable iff (sys_rst)
    (rd_en && addr == `MRT_ADDR_TIMER && reload_instant) |=> rd_data == `MRT_CNT_MAX)
    else $error("read at reload instant not ffff");
  a_halt_read: assert property (@(posedge clock) disable iff (sys_rst)
    (wr_en && addr == `MRT_ADDR_TIMER && !start) ##1 !wr_en ##1
    (rd_en && addr == `MRT_ADDR_TIMER && !start && mode != MRT_MEASURE)
    |=> rd_data == $past(wr_data, 3))
    else $error("stopped read not written value");
  a_os_stop: assert property (@(posedge clock) disable iff (sys_rst)
    (mode == MRT_ONESHOT && start && os_active && wr_stop)
    |=> (!timer_io_pin_out && irq_request && cnt == $past(reload)))
    else $error("one-shot stop effects missing");
  a_os_entry: assert property (@(posedge clock) disable iff (sys_rst)
    (wr_en && addr == `MRT_ADDR_MODE && wr_mode == MRT_ONESHOT && mode != MRT_ONESHOT)
    |=> irq_request)
    else $error("one-shot entry without request");
  a_pwm_entry: assert property (@(posedge clock) disable iff (sys_rst)
    (wr_en && addr == `MRT_ADDR_MODE && wr_is_pwm && !is_pwm) |=> irq_request)
    else $error("pwm entry without request");
  a_meas_edge: assert property (@(posedge clock) disable iff (sys_rst)
    (mode == MRT_MEASURE && start && eff_edge && !first_edge && !wr_en)
    |=> (irq_request && cnt == `MRT_CNT_MAX))
    else $error("measurement edge without request");
  a_ovf_hold: assert property (@(posedge clock) disable iff (sys_rst)
    (start && ovf && wr_en && addr == `MRT_ADDR_MODE) |=> ovf)
    else $error("overflow cleared while running");
  a_first_edge: assert property (@(posedge clock) disable iff (sys_rst)
    (mode == MRT_MEASURE && start && eff_edge && first_edge && !wr_en && !(src_tick && at_zero))
    |=> (irq_request == $past(irq_request) && reload == $past(cnt)))
    else $error("first edge raised request");
  a_sel_change: assert property (@(posedge clock) disable iff (sys_rst)
    (start && mode == MRT_MEASURE && wr_en && addr == `MRT_ADDR_MODE &&
     wr_mode == MRT_MEASURE && wr_data[`MRT_SEL_BIT] != meas_sel) |=> irq_request)
    else $error("select change without request");
  a_pwm_stop: assert property (@(posedge clock) disable iff (sys_rst)
    (is_pwm && start && wr_stop && !(src_tick && at_zero)) |=> (!timer_io_pin_out &&
    irq_request == $past(timer_io_pin_out
    || (irq_request && !(wr_en && addr == `MRT_ADDR_IRQ)))))
    else $error("pwm stop output or request wrong");
endmodule
